// [core/dio_map.svh]
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH
// ==========================================================================
// timing
`define CLK_PERIOD_NS   10
`define TICK_TIME_NS    100000
`define TICKS_PER_MS    10
`define LOCATE_TIME_MS  10000
`define GATE_TIME_MS    1000
// ==========================================================================
// register addresses
`define A_CTRL          8'h00
`define A_HOST_IDLE     8'h04
`define A_PEER_IDLE     8'h08
`define A_DO_VALUE      8'h0c
`define A_FAILSAFE      8'h10
`define A_STATUS        8'h14
`define A_DI_LEVEL      8'h18
`define A_LATCH         8'h1c
`define A_CNT_CMD       8'h20
`define A_DO_MODE       8'h24
`define CH_REGION       2'h1
`define CH_CFG          2'h0
`define CH_WIDTH        2'h1
`define CH_COUNT        2'h2
`define CH_FREQ         2'h3
// ==========================================================================
// field positions
`define CTRL_LOCATE     0
`define CTRL_PEER_EN    1
`define CMD_START       0
`define CMD_STOP        8
`define CMD_CLEAR       16
`define CFG_MODE        0
`define CFG_INVERT      3
`define CFG_FILTER      4
`define CFG_RETAIN      5
`define WID_LOW         0
`define WID_HIGH        16
`define ST_HOST_TO      0
`define ST_PEER_TO      1
`define ST_LOCATE       2
`endif

// [core/dio_pkg.sv]
package dio_pkg;
  typedef enum logic [2:0]
  {
    MODE_LEVEL = 3'h0,
    MODE_COUNT = 3'h1,
    MODE_RISE  = 3'h2,
    MODE_FALL  = 3'h3,
    MODE_FREQ  = 3'h4
  } di_mode_t;
  typedef enum logic [1:0]
  {
    WD_IDLE = 2'h0,
    WD_RUN  = 2'h1,
    WD_TRIP = 2'h3
  } wd_state_t;
endpackage

// [core/dio_chan_if.sv]
`timescale 1ns/1ps
interface dio_chan_if;
  import dio_pkg::*;
  di_mode_t    mode;
  logic        invert;
  logic        filter_en;
  logic        retain;
  logic        cold;
  logic [15:0] min_low;
  logic [15:0] min_high;
  logic        start;
  logic        stop;
  logic        clear;
  logic        clr_latch;
  logic        gate;
  logic        level;
  logic        latch;
  logic        running;
  logic [31:0] count;
  logic [31:0] freq;
  modport ctl (output mode, invert, filter_en, retain, cold, min_low, min_high, start, stop,
               clear, clr_latch, gate, input level, latch, running, count, freq);
  modport chan (input mode, invert, filter_en, retain, cold, min_low, min_high, start, stop,
                clear, clr_latch, gate, output level, latch, running, count, freq);
endinterface

// [core/dio_input_channel.sv]
`timescale 1ns/1ps
`include "dio_map.svh"
module dio_input_channel
  import dio_pkg::*;
(
  input logic         clk,   // system clock
  input logic         srst,  // synchronous reset
  input logic         tick,  // 0.1 ms enable
  input logic         din,   // raw input pin
  dio_chan_if.chan    ch     // configuration and results
);
  logic        raw;
  logic        level_q;
  logic        prev_q;
  logic        rise;
  logic        fall;
  logic        run;
  logic        latch_q;
  logic [15:0] stable_cnt;
  logic [15:0] need;
  logic [31:0] cnt;
  logic [31:0] edges;
  logic [31:0] freq_q;

  // ========================================================================
  // inversion and glitch filter
  assign raw  = din ^ ch.invert;
  assign need = raw ? ch.min_high : ch.min_low;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      level_q    <= 1'b0;
      stable_cnt <= 16'h0;
    end
    else if (!ch.filter_en)
    begin
      level_q    <= raw;
      stable_cnt <= 16'h0;
    end
    else if (raw == level_q)
      stable_cnt <= 16'h0;
    else if (tick)
    begin
      if ({1'b0, stable_cnt} + 17'h1 >= {1'b0, need})
      begin
        level_q    <= raw;
        stable_cnt <= 16'h0;
      end
      else
        stable_cnt <= stable_cnt + 16'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      prev_q <= 1'b0;
    else
      prev_q <= level_q;
  end
  assign rise = level_q & ~prev_q;
  assign fall = ~level_q & prev_q;

  // ========================================================================
  // counter
  always_ff @(posedge clk)
  begin
    if (srst)
      run <= 1'b0;
    else if (ch.start)
      run <= 1'b1;
    else if (ch.stop)
      run <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      if (ch.cold || !ch.retain)
        cnt <= 32'h0;
    end
    else if (ch.clear)
      cnt <= 32'h0;
    else if (ch.mode == MODE_COUNT && run && rise)
      cnt <= cnt + 32'h1;
  end

  // ========================================================================
  // edge latch, set wins over clear
  always_ff @(posedge clk)
  begin
    if (srst)
      latch_q <= 1'b0;
    else if ((ch.mode == MODE_RISE && rise) || (ch.mode == MODE_FALL && fall))
      latch_q <= 1'b1;
    else if (ch.clr_latch)
      latch_q <= 1'b0;
  end

  // ========================================================================
  // frequency: rising edges per gate interval
  always_ff @(posedge clk)
  begin
    if (srst || ch.mode != MODE_FREQ)
    begin
      edges  <= 32'h0;
      freq_q <= 32'h0;
    end
    else if (ch.gate)
    begin
      freq_q <= edges + {31'h0, rise};
      edges  <= 32'h0;
    end
    else if (rise)
      edges <= edges + 32'h1;
  end

  assign ch.level   = level_q;
  assign ch.latch   = latch_q;
  assign ch.running = run;
  assign ch.count   = cnt;
  assign ch.freq    = freq_q;

  // ========================================================================
  // checks
  property p_latch_hold;
    @(posedge clk) disable iff (srst) latch_q && !ch.clr_latch |=> latch_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");

  property p_rise_sets;
    @(posedge clk) disable iff (srst) ch.mode == MODE_RISE && rise |=> latch_q;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise not latched");

  property p_fall_sets;
    @(posedge clk) disable iff (srst) ch.mode == MODE_FALL && fall |=> latch_q;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall not latched");

  property p_stopped_frozen;
    @(posedge clk) disable iff (srst) !run && !ch.clear |=> $stable(cnt);
  endproperty
  a_stopped_frozen: assert property (p_stopped_frozen) else $error("count moved");

  property p_filter_tick;
    @(posedge clk) disable iff (srst)
      ch.filter_en && $past(ch.filter_en) && $changed(level_q) |-> $past(tick);
  endproperty
  a_filter_tick: assert property (p_filter_tick) else $error("filter off tick");

  property p_no_filter;
    @(posedge clk) disable iff (srst) !ch.filter_en |=> level_q == $past(raw);
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("bad unfiltered level");

  c_latch_set: cover property (@(posedge clk) disable iff (srst) !latch_q ##1 latch_q);
  c_count_up: cover property (@(posedge clk) disable iff (srst) run ##1 $changed(cnt));
endmodule // dio_input_channel

// [core/digital_io_channel_modes.sv]
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "dio_map.svh"
// Function
// - locate lights status indicator ten seconds
// - fail-safe channel driven high on timeout
// - host silence beyond idle time trips
// - peer silence trips, safety value sent
// - each input takes one of five modes
// - inversion complements the sampled input level
// - filter rejects pulses below programmed widths
// - level mode reports processed input state
// - counter mode counts processed input pulses
// - host starts and stops each counter
// - clear command zeroes the count
// - retain keeps count across power loss
// - readable count tracks live count
// - rising edge sets latch status
// - latch holds until host clears it
// - falling edge sets latch status
// - frequency mode measures input frequency
// - outputs offer four output modes; do_mode is only stored and read back, every output drives the direct value
// - direct mode drives host written value
// - output levels readable as status
module digital_io_channel_modes
  import dio_pkg::*;
#(
  parameter int N_IN         = 4,
  parameter int N_OUT        = 4,
  parameter int TICK_CYCLES  = `TICK_TIME_NS / `CLK_PERIOD_NS,
  parameter int LOCATE_TICKS = `LOCATE_TIME_MS * `TICKS_PER_MS,
  parameter int GATE_TICKS   = `GATE_TIME_MS * `TICKS_PER_MS
)
(
  input  logic             CLK_SYS,        // 100 MHz clock
  input  logic             SRST,           // synchronous reset, high
  input  logic             COLD_START,     // reset also clears retained counts
  input  logic [7:0]       ADDR,           // register byte address
  input  logic [31:0]      WDATA,          // write data
  input  logic             WR,             // write strobe
  input  logic             RD,             // read strobe
  output logic [31:0]      RDATA,          // read data, cycle after RD
  input  logic [N_IN-1:0]  DIN,            // field inputs
  input  logic             HOST_PKT,       // pulse per host packet
  input  logic             PEER_PKT,       // pulse per peer packet
  output logic [N_OUT-1:0] DO,             // field outputs
  output logic [N_IN-1:0]  DI_LED,         // processed input indicators
  output logic             LED_STATUS,     // status indicator
  output logic             PEER_SAFE_SEND  // pulse: send safety value
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int LW = $clog2(LOCATE_TICKS + 1);
  localparam int GW = $clog2(GATE_TICKS);

  logic [TW-1:0]    tick_cnt;
  logic             tick;
  logic [GW-1:0]    gate_cnt;
  logic             gate;
  logic [LW-1:0]    locate_cnt;
  logic             peer_en;
  logic [15:0]      idle [2];
  logic [15:0]      elapsed [2];
  wd_state_t        wd_st [2];
  logic [1:0]       wd_en;
  logic [1:0]       pkt;
  logic             peer_prev;
  logic [N_OUT-1:0] do_value;
  logic [N_OUT-1:0] failsafe;
  logic [7:0]       do_mode;
  logic [5:0]       cfg [N_IN];
  logic [31:0]      wid [N_IN];
  logic [N_IN-1:0]  retain;
  logic [N_IN-1:0]  start_p;
  logic [N_IN-1:0]  stop_p;
  logic [N_IN-1:0]  clear_p;
  logic [N_IN-1:0]  clr_latch_p;
  logic [N_IN-1:0]  lvl;
  logic [N_IN-1:0]  lat;
  logic [N_IN-1:0]  run;
  logic [31:0]      cnt_a [N_IN];
  logic [31:0]      frq_a [N_IN];
  logic             ch_hit;
  logic [1:0]       ch_idx;
  logic [31:0]      next_rdata;

  assign ch_hit = (ADDR[7:6] == `CH_REGION) && ({30'h0, ADDR[5:4]} < N_IN);
  assign ch_idx = ADDR[5:4];

  // ========================================================================
  // time base
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || gate)
      gate_cnt <= '0;
    else if (tick)
      gate_cnt <= gate_cnt + 1'b1;
  end
  assign gate = tick && (gate_cnt == GW'(GATE_TICKS - 1));

  // ========================================================================
  // global registers
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      peer_en  <= 1'b0;
      idle[0]  <= 16'h0;
      idle[1]  <= 16'h0;
      do_value <= '0;
      failsafe <= '0;
      do_mode  <= 8'h0;
    end
    else if (WR)
    begin
      case (ADDR)
        `A_CTRL:      peer_en  <= WDATA[`CTRL_PEER_EN];
        `A_HOST_IDLE: idle[0]  <= WDATA[15:0];
        `A_PEER_IDLE: idle[1]  <= WDATA[15:0];
        `A_DO_VALUE:  do_value <= WDATA[N_OUT-1:0];
        `A_FAILSAFE:  failsafe <= WDATA[N_OUT-1:0];
        `A_DO_MODE:   do_mode  <= WDATA[7:0];
        default:      peer_en  <= peer_en;
      endcase
    end
  end

  // ========================================================================
  // locate
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      locate_cnt <= '0;
    else if (WR && ADDR == `A_CTRL && WDATA[`CTRL_LOCATE])
      locate_cnt <= LW'(LOCATE_TICKS);
    else if (tick && locate_cnt != '0)
      locate_cnt <= locate_cnt - 1'b1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      LED_STATUS <= 1'b0;
    else
      LED_STATUS <= (locate_cnt != '0);
  end

  // ========================================================================
  // host and peer watchdogs
  assign wd_en = {peer_en && idle[1] != 16'h0, idle[0] != 16'h0};
  assign pkt   = {PEER_PKT, HOST_PKT};

  for (genvar w = 0; w < 2; w++)
  begin : g_wd
    always_ff @(posedge CLK_SYS)
    begin
      if (SRST || !wd_en[w])
      begin
        wd_st[w]   <= WD_IDLE;
        elapsed[w] <= 16'h0;
      end
      else
      begin
        case (wd_st[w])
          WD_IDLE:
          begin
            wd_st[w]   <= WD_RUN;
            elapsed[w] <= 16'h0;
          end
          WD_RUN:
          begin
            if (pkt[w])
              elapsed[w] <= 16'h0;
            else if (tick && elapsed[w] >= idle[w])
              wd_st[w] <= WD_TRIP;
            else if (tick)
              elapsed[w] <= elapsed[w] + 16'h1;
          end
          WD_TRIP:
          begin
            if (pkt[w])
            begin
              wd_st[w]   <= WD_RUN;
              elapsed[w] <= 16'h0;
            end
          end
          default:
            wd_st[w] <= WD_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      peer_prev      <= 1'b0;
      PEER_SAFE_SEND <= 1'b0;
    end
    else
    begin
      peer_prev      <= (wd_st[1] == WD_TRIP);
      PEER_SAFE_SEND <= (wd_st[1] == WD_TRIP) && !peer_prev;
    end
  end

  // ========================================================================
  // outputs: every output mode falls back to direct level
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      DO <= '0;
    else if (wd_st[0] == WD_TRIP)
      DO <= do_value | failsafe;
    else
      DO <= do_value;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      DI_LED <= '0;
    else
      DI_LED <= lvl;
  end

  // ========================================================================
  // input channels
  for (genvar i = 0; i < N_IN; i++)
  begin : g_ch
    dio_chan_if cif ();

    always_ff @(posedge CLK_SYS)
    begin
      if (SRST)
      begin
        cfg[i] <= 6'h0;
        wid[i] <= {16'h1, 16'h1};
      end
      else if (WR && ch_hit && ch_idx == 2'(i))
      begin
        if (ADDR[3:2] == `CH_CFG)
          cfg[i] <= WDATA[5:0];
        if (ADDR[3:2] == `CH_WIDTH)
          wid[i] <= WDATA;
      end
    end

    always_ff @(posedge CLK_SYS)
    begin
      if (SRST && COLD_START)
        retain[i] <= 1'b0;
      else if (!SRST && WR && ch_hit && ch_idx == 2'(i) && ADDR[3:2] == `CH_CFG)
        retain[i] <= WDATA[`CFG_RETAIN];
    end

    always_ff @(posedge CLK_SYS)
    begin
      if (SRST)
      begin
        start_p[i]     <= 1'b0;
        stop_p[i]      <= 1'b0;
        clear_p[i]     <= 1'b0;
        clr_latch_p[i] <= 1'b0;
      end
      else
      begin
        start_p[i]     <= WR && ADDR == `A_CNT_CMD && WDATA[`CMD_START + i];
        stop_p[i]      <= WR && ADDR == `A_CNT_CMD && WDATA[`CMD_STOP + i];
        clear_p[i]     <= WR && ADDR == `A_CNT_CMD && WDATA[`CMD_CLEAR + i];
        clr_latch_p[i] <= WR && ADDR == `A_LATCH && WDATA[i];
      end
    end

    assign cif.mode      = di_mode_t'(cfg[i][`CFG_MODE +: 3]);
    assign cif.invert    = cfg[i][`CFG_INVERT];
    assign cif.filter_en = cfg[i][`CFG_FILTER];
    assign cif.retain    = retain[i];
    assign cif.cold      = COLD_START;
    assign cif.min_low   = wid[i][`WID_LOW +: 16];
    assign cif.min_high  = wid[i][`WID_HIGH +: 16];
    assign cif.start     = start_p[i];
    assign cif.stop      = stop_p[i];
    assign cif.clear     = clear_p[i];
    assign cif.clr_latch = clr_latch_p[i];
    assign cif.gate      = gate;
    assign lvl[i]        = cif.level;
    assign lat[i]        = cif.latch;
    assign run[i]        = cif.running;
    assign cnt_a[i]      = cif.count;
    assign frq_a[i]      = cif.freq;

    dio_input_channel u_ch
    (
      .clk  (CLK_SYS),
      .srst (SRST),
      .tick (tick),
      .din  (DIN[i]),
      .ch   (cif.chan)
    );
  end

  // ========================================================================
  // read path
  always_comb
  begin
    next_rdata = 32'h0;
    if (ch_hit)
    begin
      case (ADDR[3:2])
        `CH_CFG:   next_rdata = {26'h0, retain[ch_idx], cfg[ch_idx][4:0]};
        `CH_WIDTH: next_rdata = wid[ch_idx];
        `CH_COUNT: next_rdata = cnt_a[ch_idx];
        `CH_FREQ:  next_rdata = frq_a[ch_idx];
        default:   next_rdata = 32'h0;
      endcase
    end
    else
    begin
      case (ADDR)
        `A_CTRL:      next_rdata = {30'h0, peer_en, 1'b0};
        `A_HOST_IDLE: next_rdata = {16'h0, idle[0]};
        `A_PEER_IDLE: next_rdata = {16'h0, idle[1]};
        `A_DO_VALUE:  next_rdata = 32'(DO);
        `A_FAILSAFE:  next_rdata = 32'(failsafe);
        `A_STATUS:    next_rdata = {29'h0, LED_STATUS, wd_st[1] == WD_TRIP,
                                    wd_st[0] == WD_TRIP};
        `A_DI_LEVEL:  next_rdata = 32'(lvl);
        `A_LATCH:     next_rdata = 32'(lat);
        `A_CNT_CMD:   next_rdata = 32'(run);
        `A_DO_MODE:   next_rdata = {24'h0, do_mode};
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !RD)
      RDATA <= 32'h0;
    else
      RDATA <= next_rdata;
  end

  // ========================================================================
  // checks
  property p_failsafe_high;
    @(posedge CLK_SYS) disable iff (SRST) wd_st[0] == WD_TRIP |=> (DO & $past(failsafe))
      == $past(failsafe);
  endproperty
  a_failsafe_high: assert property (p_failsafe_high) else $error("fail-safe not high");

  property p_direct;
    @(posedge CLK_SYS) disable iff (SRST) wd_st[0] != WD_TRIP |=> DO == $past(do_value);
  endproperty
  a_direct: assert property (p_direct) else $error("output not direct");

  property p_host_trip;
    @(posedge CLK_SYS) disable iff (SRST)
      wd_en[0] && wd_st[0] == WD_RUN && tick && !HOST_PKT && elapsed[0] >= idle[0]
      |=> wd_st[0] == WD_TRIP;
  endproperty
  a_host_trip: assert property (p_host_trip) else $error("host watchdog missed");

  property p_peer_send;
    @(posedge CLK_SYS) disable iff (SRST)
      $rose(wd_st[1] == WD_TRIP) |=> PEER_SAFE_SEND ##1 !PEER_SAFE_SEND;
  endproperty
  a_peer_send: assert property (p_peer_send) else $error("peer safety not sent");

  property p_locate_on;
    @(posedge CLK_SYS) disable iff (SRST)
      WR && ADDR == `A_CTRL && WDATA[`CTRL_LOCATE] |=> ##1 LED_STATUS;
  endproperty
  a_locate_on: assert property (p_locate_on) else $error("locate led off");

  property p_status_read;
    @(posedge CLK_SYS) disable iff (SRST)
      RD && ADDR == `A_DO_VALUE |=> RDATA == 32'($past(DO));
  endproperty
  a_status_read: assert property (p_status_read) else $error("bad output status");

  c_host_trip: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(wd_st[0] == WD_TRIP));
  c_locate_end: cover property (@(posedge CLK_SYS) disable iff (SRST) $fell(LED_STATUS));
  c_peer_send: cover property (@(posedge CLK_SYS) disable iff (SRST) PEER_SAFE_SEND);
endmodule // digital_io_channel_modes

// [bench/field_side.sv]
`timescale 1ns/1ps
// ======================================
// field pins and network packets
module field_side
(
  input  wire logic       clk,       // system clock
  input  wire logic [3:0] level,     // wanted field levels
  input  wire logic       host_send, // one host packet
  input  wire logic       peer_send, // one peer packet
  output logic [3:0]      din,       // field pins
  output logic            host_pkt,  // host packet pulse
  output logic            peer_pkt   // peer packet pulse
);
  always_ff @(posedge clk)
  begin
    din      <= level;
    host_pkt <= host_send;
    peer_pkt <= peer_send;
  end
endmodule // field_side

// [bench/digital_io_channel_modes_tb.sv]
`timescale 1ns/1ps
`include "dio_map.svh"
module digital_io_channel_modes_tb;
  import dio_pkg::*;
  logic        clk_sys, srst, cold_start, wr, rd, host_send, peer_send;
  logic        host_pkt, peer_pkt, led_status, peer_safe_send;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  level, din, do_pins, di_led;
  int          fail_count, check_count, n;
  logic [7:0]  rows [4] = '{8'h55, 8'haa, 8'hff, 8'h00}; // written value, expected pins

  field_side field_side_inst (.clk(clk_sys), .level(level), .host_send(host_send),
    .peer_send(peer_send), .din(din), .host_pkt(host_pkt), .peer_pkt(peer_pkt));

  digital_io_channel_modes #(.N_IN(4), .N_OUT(4), .TICK_CYCLES(4), .LOCATE_TICKS(5),
    .GATE_TICKS(8)) digital_io_channel_modes_inst (.CLK_SYS(clk_sys), .SRST(srst),
    .COLD_START(cold_start), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .DIN(din), .HOST_PKT(host_pkt), .PEER_PKT(peer_pkt), .DO(do_pins),
    .DI_LED(di_led), .LED_STATUS(led_status), .PEER_SAFE_SEND(peer_safe_send));

  // ======================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic pulse(input int ch);
    level[ch] <= 1'b1;
    cyc(4);
    level[ch] <= 1'b0;
    cyc(4);
  endtask
  task automatic reset_dut(input logic cold);
    srst       <= 1'b1;
    cold_start <= cold;
    cyc(3);
    srst       <= 1'b0;
    cold_start <= 1'b0;
    cyc(2);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ======================================
  // clock, watchdog, sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #20000;
    fail_count++;
    stop_test();
  end
  initial
  begin
    {srst, cold_start} = 2'b11;
    {wr, rd, host_send, peer_send} = 4'h0;
    addr = 8'h00;
    wdata = 32'h0;
    level = 4'h0;
    fail_count = 0;
    check_count = 0;
    cyc(20);
    srst <= 1'b0;
    cold_start <= 1'b0;
    cyc(1);
    chk({28'h0, do_pins}, 32'h0);
    chk({31'h0, led_status}, 32'h0);
    foreach (rows[i])
    begin
      wreg(`A_DO_VALUE, {28'h0, rows[i][7:4]});
      cyc(2);
      chk({28'h0, do_pins}, {28'h0, rows[i][3:0]});
      rreg(`A_DO_VALUE);
      chk(d, {28'h0, rows[i][3:0]});
    end
    rreg(8'h3c);
    chk(d, 32'h0);
    // inverted idle input reads high
    wreg(8'h40, 32'h8);
    cyc(3);
    rreg(`A_DI_LEVEL);
    chk(d, 32'h1);
    chk({28'h0, di_led}, 32'h1);
    // counter on channel 1: start, count, stop, clear
    wreg(8'h50, 32'h1);
    wreg(`A_CNT_CMD, 32'h2);
    cyc(2);
    repeat (3) pulse(1);
    rreg(8'h58);
    chk(d, 32'h3);
    wreg(`A_CNT_CMD, 32'h200);
    cyc(2);
    pulse(1);
    rreg(8'h58);
    chk(d, 32'h3);
    wreg(`A_CNT_CMD, 32'h20000);
    cyc(2);
    rreg(8'h58);
    chk(d, 32'h0);
    // rising latch on channel 2, falling latch on channel 3
    wreg(8'h60, 32'h2);
    wreg(8'h70, 32'h3);
    cyc(2);
    pulse(2);
    rreg(`A_LATCH);
    chk(d, 32'h4);
    pulse(3);
    rreg(`A_LATCH);
    chk(d, 32'hc);
    wreg(`A_LATCH, 32'hc);
    cyc(2);
    rreg(`A_LATCH);
    chk(d, 32'h0);
    // filter on channel 2: one-tick high rejected, five-tick high accepted
    wreg(8'h64, 32'h00030001);
    wreg(8'h60, 32'h12);
    cyc(2);
    pulse(2);
    rreg(`A_LATCH);
    chk(d, 32'h0);
    level[2] <= 1'b1;
    cyc(20);
    level[2] <= 1'b0;
    cyc(8);
    rreg(`A_LATCH);
    chk(d, 32'h4);
    // frequency on channel 0: 8-cycle period gives 4 edges per 32-cycle gate
    wreg(8'h40, 32'h4);
    fork
      repeat (20) pulse(0);
      begin
        cyc(80);
        rreg(8'h4c);
      end
    join
    chk(d, 32'h4);
    // host silence forces fail-safe high on output 0
    wreg(`A_FAILSAFE, 32'h1);
    wreg(`A_HOST_IDLE, 32'h3);
    n = 0;
    while (do_pins !== 4'h1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    chk({28'h0, do_pins}, 32'h1);
    rreg(`A_STATUS);
    chk(d & 32'h1, 32'h1);
    host_send <= 1'b1;
    cyc(1);
    host_send <= 1'b0;
    cyc(3);
    chk({28'h0, do_pins}, 32'h0);
    wreg(`A_HOST_IDLE, 32'h0);
    // peer silence asks for the safety value to be sent
    wreg(`A_PEER_IDLE, 32'h2);
    wreg(`A_CTRL, 32'h2);
    n = 0;
    while (peer_safe_send !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    chk({31'h0, peer_safe_send}, 32'h1);
    // locate lights the status indicator for the locate span only
    wreg(`A_CTRL, 32'h1);
    cyc(2);
    chk({31'h0, led_status}, 32'h1);
    cyc(30);
    chk({31'h0, led_status}, 32'h0);
    // warm reset keeps a retained count, cold reset clears it
    wreg(`A_DO_VALUE, 32'hf);
    wreg(8'h50, 32'h21);
    wreg(`A_CNT_CMD, 32'h2);
    cyc(2);
    repeat (2) pulse(1);
    reset_dut(1'b0);
    chk({28'h0, do_pins}, 32'h0);
    rreg(8'h58);
    chk(d, 32'h2);
    reset_dut(1'b1);
    rreg(8'h58);
    chk(d, 32'h0);
    stop_test();
  end
endmodule // digital_io_channel_modes_tb
